// *** hw/twc_ctrl.sv ***
// Contract
// - Master: strobe clocks one byte; hardware clears strobe after the handshake.
// - Slave: bit 7 is pending, SCL held until software clears it.
// - Role bit 0 selects slave (default), 1 selects master.
// - Speed bit chooses standard or fast rate and the divider table.
// - Master STOP request: read ends with NACK then STOP; write STOPs after ACK.
// - Slave with STOP request while written to answers NACK.
// - Address-sent flag sets after address byte handshake, clears on address write.
// - Ack status follows the last ninth-bit ACK or NACK, whether the peer or this controller gave it.
// - Receive-full sets while a byte waits, clears as software reads it.
// - Transmit-empty sets after send and handshake, clears on buffer write.
// - Slave busy on START, clears on STOP, mismatch, disable; master busy START-STOP.
// - Clearing soft reset bit resets the state machine and releases SCL.
// - Fast speed divisors 10,15,20,25,30,40,50,60 for select codes 0-7.
// - Standard speed divisors 40,60,80,100,120,160,200,240 for select codes 0-7.
// - Enable switches on, initialises the state machine, keeps registers.
// - Target address register: address in bits 7-1, direction in bit 0.
// - Slave matches 7-bit addresses against own address bits 6-0, 10-bit addresses against all 10 bits.
// - Receive, transmit and stop status flags; writes or disable clear rx/tx.
// - Second port: tx/rx/stop flags, stop enable; stop flag takes stop enable on tx/rx flag writes.
// - START and STOP are SDA edges with SCL high; SDA changes while SCL low.
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Receive FIFO
// ****************************************************************
module twc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wp;
		logic [AW:0]                 rp;
	} twc_fifo_s;

	twc_fifo_s s;
	twc_fifo_s next_s;
	logic [AW:0] fill;

	// Occupancy and handshakes
	assign fill      = s.wp - s.rp;
	assign in_ready  = (fill != (AW+1)'(DEPTH));
	assign out_valid = (fill != '0);
	assign out_data  = s.mem[s.rp[AW-1:0]];

	// Pointer and storage update
	always_comb begin
		next_s = s;
		if (in_valid && in_ready) begin
			next_s.mem[s.wp[AW-1:0]] = in_data;
			next_s.wp = s.wp + 1'b1;
		end
		if (out_valid && out_ready) begin
			next_s.rp = s.rp + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule : twc_fifo

// ****************************************************************
// Two-wire controller
// ****************************************************************
module twc_ctrl
	import twc_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire twc_sfr_req_s sfr_req,
	output logic        [7:0] sfr_rdata,
	input  wire logic         scl_in,
	input  wire logic         sda_in,
	output twc_pad_s          pad
);
	typedef struct packed {
		twc_state_e state;
		logic [1:0] ph;
		logic [7:0] tick;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic       strobe, role, speed, stopreq, asent, ack, tx_empty;
		logic       sbusy, srst_n, mbusy, en;
		logic [2:0] sel;
		logic [7:0] tsa, txd, oal;
		logic [1:0] oah;
		logic       fstop, frx, ftx;
		logic [3:0] b_int, b_cr1;
		logic [7:0] rdata;
		twc_pad_s   pad;
		logic       scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
		logic       started, is_addr, rw, ten, addr10, acked, newaddr;
		logic       push, pop;
		logic [7:0] push_data;
	} twc_core_s;

	twc_core_s  s;
	twc_core_s  next_s;
	logic       fifo_ready;
	logic       fifo_valid;
	logic [7:0] fifo_data;

	// Quarter of an SCL period; the four phases add up to the divisor
	function automatic logic [7:0] phase_len(input logic [7:0] div, input logic [1:0] ph);
		logic [8:0] t;
		t = {1'b0, div} + 9'h003 - {7'h00, ph};
		return {1'b0, t[8:2]} - 8'h01;
	endfunction : phase_len

	twc_fifo #(.WIDTH(TWC_FIFO_W), .DEPTH(TWC_FIFO_D)) u_rx_fifo (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.in_valid  (s.push),
		.in_ready  (fifo_ready),
		.in_data   (s.push_data),
		.out_valid (fifo_valid),
		.out_ready (s.pop),
		.out_data  (fifo_data)
	);

	assign sfr_rdata = s.rdata;
	assign pad       = s.pad;

	// Next state of the whole controller
	always_comb begin
		logic       b_start, b_stop, rise, fall, tick, ok;
		logic [7:0] div, nbyte;
		next_s = s;
		next_s.push = 1'b0;
		next_s.pop  = 1'b0;
		// Two-stage pin synchronisers, then a history stage
		next_s.scl_m = scl_in;
		next_s.scl_s = s.scl_m;
		next_s.scl_p = s.scl_s;
		next_s.sda_m = sda_in;
		next_s.sda_s = s.sda_m;
		next_s.sda_p = s.sda_s;
		b_start = s.scl_s && s.scl_p && s.sda_p && !s.sda_s;
		b_stop  = s.scl_s && s.scl_p && !s.sda_p && s.sda_s;
		rise    = s.scl_s && !s.scl_p;
		fall    = !s.scl_s && s.scl_p;
		ok      = 1'b0;
		nbyte   = s.rw ? 8'hFF : s.txd;
		div     = s.speed ? TWC_DIV_FAST[s.sel] : TWC_DIV_STD[s.sel];
		tick    = (s.tick == 8'h00);
		next_s.tick = tick ? phase_len(div, s.ph + 2'h1) : s.tick - 8'h01;

		// Register writes; hardware events below take priority
		if (sfr_req.wr) begin
			case (sfr_req.addr)
				TWC_OFF_CR1: begin
					next_s.strobe  = sfr_req.wdata[TWC_B_STROBE];
					next_s.role    = sfr_req.wdata[TWC_B_ROLE];
					next_s.speed   = sfr_req.wdata[TWC_B_SPEED];
					next_s.stopreq = sfr_req.wdata[TWC_B_STOP];
				end
				TWC_OFF_CR2: begin
					next_s.srst_n = sfr_req.wdata[TWC_B_SRST];
					next_s.sel    = sfr_req.wdata[TWC_B_SEL +: 3];
					next_s.en     = sfr_req.wdata[TWC_B_EN];
				end
				TWC_OFF_TSA: begin
					next_s.tsa     = sfr_req.wdata;
					next_s.asent   = 1'b0;
					next_s.newaddr = 1'b1;
				end
				TWC_OFF_DBUF: begin
					next_s.txd      = sfr_req.wdata;
					next_s.tx_empty = 1'b0;
				end
				TWC_OFF_OAL: next_s.oal = sfr_req.wdata;
				TWC_OFF_OAH: next_s.oah = sfr_req.wdata[1:0];
				TWC_OFF_FLG: {next_s.fstop, next_s.frx, next_s.ftx} = sfr_req.wdata[2:0];
				TWC_OFF_BINT: begin
					next_s.b_int = sfr_req.wdata[7:4];
					if (sfr_req.wdata[7] || sfr_req.wdata[6]) begin
						next_s.b_int[0] = s.b_cr1[0];
					end
				end
				TWC_OFF_BCR1: next_s.b_cr1 = sfr_req.wdata[7:4];
				default: ;
			endcase
		end

		// Register reads; a data buffer read pops the receive FIFO
		if (sfr_req.rd) begin
			case (sfr_req.addr)
				TWC_OFF_CR1: next_s.rdata = {s.strobe, s.role, s.speed, s.stopreq,
					s.asent, s.ack, fifo_valid, s.tx_empty};
				TWC_OFF_CR2: next_s.rdata = {s.sbusy, 1'b0, s.srst_n, s.mbusy,
					s.sel, s.en};
				TWC_OFF_TSA:  next_s.rdata = s.tsa;
				TWC_OFF_DBUF: next_s.rdata = fifo_valid ? fifo_data : s.txd;
				TWC_OFF_OAL:  next_s.rdata = s.oal;
				TWC_OFF_OAH:  next_s.rdata = {6'h00, s.oah};
				TWC_OFF_FLG:  next_s.rdata = {5'h00, s.fstop, s.frx, s.ftx};
				TWC_OFF_BINT: next_s.rdata = {s.b_int, 4'h0};
				TWC_OFF_BCR1: next_s.rdata = {s.b_cr1, TWC_RST_BCR1[3:0]};
				default:      next_s.rdata = 8'h00;
			endcase
			next_s.pop = (sfr_req.addr == TWC_OFF_DBUF) && fifo_valid;
		end

		// Bus-level flags
		if (b_start) begin
			next_s.mbusy = 1'b1;
		end
		if (b_stop) begin
			next_s.mbusy = 1'b0;
			next_s.fstop = 1'b1;
		end

		// Protocol engine
		case (s.state)
			TWC_IDLE: begin
				next_s.pad.scl_oe_n = 1'b1;
				next_s.pad.sda_oe_n = 1'b1;
				if (s.role && s.strobe) begin
					next_s.state = TWC_M_START;
					next_s.ph    = 2'h0;
					next_s.tick  = phase_len(div, 2'h0);
				end
			end
			// Master start or repeated start
			TWC_M_START: begin
				if (tick) begin
					next_s.ph = s.ph + 2'h1;
					case (s.ph)
						2'h0: next_s.pad.scl_oe_n = 1'b1;
						2'h1: next_s.pad.sda_oe_n = 1'b0;
						2'h2: ;
						default: begin
							next_s.pad.scl_oe_n = 1'b0;
							next_s.state   = TWC_M_BIT;
							next_s.cnt     = 4'h0;
							next_s.is_addr = 1'b1;
							next_s.rw      = s.tsa[0];
							next_s.shift   = s.tsa;
							next_s.newaddr = 1'b0;
							next_s.started = 1'b1;
						end
					endcase
				end
			end
			// Master bit cell: set SDA, raise SCL, sample, drop SCL
			TWC_M_BIT: begin
				if (tick) begin
					next_s.ph = s.ph + 2'h1;
					case (s.ph)
						2'h0: begin
							if (s.cnt != TWC_ACK_SLOT) begin
								next_s.pad.sda_oe_n = (s.is_addr || !s.rw) ? s.shift[7] : 1'b1;
							end else if (s.is_addr || !s.rw) begin
								next_s.pad.sda_oe_n = 1'b1;
							end else if (!fifo_ready) begin
								next_s.ph   = s.ph; // FIFO full: stretch low phase
								next_s.tick = phase_len(div, s.ph);
							end else begin
								next_s.push      = 1'b1;
								next_s.push_data = s.shift;
								next_s.pad.sda_oe_n = s.stopreq;
							end
						end
						2'h1: next_s.pad.scl_oe_n = 1'b1;
						2'h2: begin
							if (s.cnt != TWC_ACK_SLOT) begin
								next_s.shift = {s.shift[6:0], s.sda_s};
							end else begin
								next_s.acked = (s.is_addr || !s.rw) ? !s.sda_s : !s.stopreq;
							end
						end
						default: begin
							next_s.pad.scl_oe_n = 1'b0;
							next_s.cnt = s.cnt + 4'h1;
							if (s.cnt == TWC_ACK_SLOT) begin
								next_s.strobe = 1'b0;
								next_s.ack    = s.acked;
								if (s.is_addr) begin
									next_s.asent = 1'b1;
								end
								if (s.is_addr || !s.rw) begin
									next_s.ftx      = 1'b1;
									next_s.tx_empty = 1'b1;
								end else if (s.acked) begin
									next_s.frx = 1'b1;
								end
								next_s.is_addr = 1'b0;
								next_s.state   = s.stopreq ? TWC_M_STOP : TWC_M_HOLD;
							end
						end
					endcase
				end
			end
			// Master holds SCL low until the next strobe
			TWC_M_HOLD: begin
				next_s.pad.sda_oe_n = 1'b1;
				if (!s.role) begin
					next_s.state = TWC_IDLE;
				end else if (s.strobe && s.newaddr) begin
					next_s.state = TWC_M_START;
					next_s.ph    = 2'h0;
					next_s.tick  = phase_len(div, 2'h0);
				end else if (s.strobe) begin
					next_s.state = TWC_M_BIT;
					next_s.ph    = 2'h0;
					next_s.cnt   = 4'h0;
					next_s.shift = nbyte;
					next_s.tick  = phase_len(div, 2'h0);
				end
			end
			// Master stop: SDA low, SCL high, SDA high
			TWC_M_STOP: begin
				if (tick) begin
					next_s.ph = s.ph + 2'h1;
					case (s.ph)
						2'h0: next_s.pad.sda_oe_n = 1'b0;
						2'h1: next_s.pad.scl_oe_n = 1'b1;
						2'h2: next_s.pad.sda_oe_n = 1'b1;
						default: begin
							next_s.stopreq = 1'b0;
							next_s.started = 1'b0;
							next_s.state   = TWC_IDLE;
						end
					endcase
				end
			end
			// Slave receives address or data
			TWC_S_RX: begin
				if (rise && s.cnt < TWC_ACK_SLOT) begin
					next_s.shift = {s.shift[6:0], s.sda_s};
					next_s.cnt   = s.cnt + 4'h1;
				end else if (rise && s.cnt == TWC_ACK_CLK) begin
					next_s.cnt = TWC_ACK_DONE;
				end
				if (s.cnt == TWC_ACK_SLOT && !s.scl_s) begin
					if (!fifo_ready) begin
						next_s.pad.scl_oe_n = 1'b0; // FIFO full: stretch
					end else begin
						if (!s.is_addr) begin
							ok = !s.stopreq;
						end else if (s.ten) begin
							ok = (s.shift == s.oal);
							next_s.is_addr = !ok;
							next_s.addr10  = ok;
							next_s.ten     = 1'b0;
							next_s.rw      = 1'b0;
						end else if (s.shift[7:3] == TWC_TEN_PREFIX && s.shift[2:1] == s.oah) begin
							ok = !s.shift[0] || s.addr10;
							next_s.ten     = !s.shift[0];
							next_s.is_addr = !s.shift[0] || !ok; // Refused read keeps busy clear path
							next_s.rw      = s.shift[0];
						end else begin
							ok = (s.shift[7:1] == s.oal[6:0]);
							next_s.is_addr = !ok; // Mismatch drops slave busy
							next_s.rw      = s.shift[0];
						end
						next_s.acked        = ok;
						next_s.push         = ok;
						next_s.push_data    = s.shift;
						next_s.pad.sda_oe_n = !ok;
						next_s.pad.scl_oe_n = 1'b1;
						next_s.cnt          = TWC_ACK_CLK;
					end
				end
				if (s.cnt == TWC_ACK_DONE && !s.scl_s) begin
					next_s.pad.sda_oe_n = 1'b1;
					next_s.ack = s.acked;
					if (s.acked) begin
						next_s.strobe = 1'b1;
						next_s.frx    = 1'b1;
						next_s.pad.scl_oe_n = 1'b0;
						next_s.state  = TWC_S_WAIT;
					end else begin
						next_s.state = TWC_S_IGN;
						if (s.is_addr) begin
							next_s.sbusy = 1'b0;
						end
					end
				end
			end
			// Slave holds SCL until software clears pending
			TWC_S_WAIT: begin
				next_s.pad.scl_oe_n = 1'b0;
				if (!s.strobe) begin
					next_s.pad.scl_oe_n = 1'b1;
					next_s.cnt = 4'h0;
					if (s.rw) begin
						next_s.state = TWC_S_TX;
						next_s.shift = s.txd;
						next_s.pad.sda_oe_n = s.txd[7];
					end else begin
						next_s.state = TWC_S_RX;
					end
				end
			end
			// Slave transmits; bits change only on falling SCL
			TWC_S_TX: begin
				if (rise && s.cnt == TWC_ACK_SLOT) begin
					next_s.acked = !s.sda_s;
					next_s.cnt   = TWC_ACK_CLK;
				end else if (rise) begin
					next_s.cnt = s.cnt + 4'h1;
				end
				if (fall && s.cnt < TWC_ACK_SLOT) begin
					next_s.shift = {s.shift[6:0], 1'b1};
					next_s.pad.sda_oe_n = s.shift[6];
				end else if (fall && s.cnt == TWC_ACK_SLOT) begin
					next_s.pad.sda_oe_n = 1'b1;
				end else if (fall && s.cnt == TWC_ACK_CLK) begin
					next_s.ack      = s.acked;
					next_s.ftx      = 1'b1;
					next_s.tx_empty = 1'b1;
					if (s.acked) begin
						next_s.strobe = 1'b1;
						next_s.pad.scl_oe_n = 1'b0;
						next_s.state  = TWC_S_WAIT;
					end else begin
						next_s.state = TWC_S_IGN;
					end
				end
			end
			TWC_S_IGN: begin
				next_s.pad.scl_oe_n = 1'b1;
				next_s.pad.sda_oe_n = 1'b1;
			end
			default: next_s.state = TWC_IDLE;
		endcase

		// Slave follows START and STOP in any state
		if (!s.role && b_start) begin
			next_s.state   = TWC_S_RX;
			next_s.cnt     = 4'h0;
			next_s.is_addr = 1'b1;
			next_s.sbusy   = 1'b1;
			next_s.pad.scl_oe_n = 1'b1;
			next_s.pad.sda_oe_n = 1'b1;
		end else if (!s.role && b_stop) begin
			next_s.state  = TWC_IDLE;
			next_s.sbusy  = 1'b0;
			next_s.addr10 = 1'b0;
			next_s.ten    = 1'b0;
		end

		// Disable or soft reset: state machine back to idle, pads released
		if (!s.en || !s.srst_n) begin
			next_s.state   = TWC_IDLE;
			next_s.pad.scl_oe_n = 1'b1;
			next_s.pad.sda_oe_n = 1'b1;
			next_s.started = 1'b0;
			next_s.addr10  = 1'b0;
			next_s.ten     = 1'b0;
			if (!s.en) begin
				next_s.sbusy = 1'b0;
				next_s.frx   = 1'b0;
				next_s.ftx   = 1'b0;
			end
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s <= '0;
			s.state  <= TWC_IDLE;
			s.srst_n <= TWC_RST_CR2[TWC_B_SRST];
			s.b_cr1  <= TWC_RST_BCR1[7:4];
			s.pad    <= '{scl_out: 1'b0, scl_oe_n: 1'b1, sda_out: 1'b0, sda_oe_n: 1'b1};
			s.scl_m  <= 1'b1;
			s.scl_s  <= 1'b1;
			s.scl_p  <= 1'b1;
			s.sda_m  <= 1'b1;
			s.sda_s  <= 1'b1;
			s.sda_p  <= 1'b1;
		end else begin
			s <= next_s;
		end
	end
endmodule : twc_ctrl

`default_nettype wire

// *** hw/twc_pkg.sv ***
package twc_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] TWC_OFF_CR1  = 8'hC1;
	localparam logic [7:0] TWC_OFF_CR2  = 8'hC2;
	localparam logic [7:0] TWC_OFF_TSA  = 8'hC3;
	localparam logic [7:0] TWC_OFF_DBUF = 8'hC4;
	localparam logic [7:0] TWC_OFF_OAL  = 8'hC5;
	localparam logic [7:0] TWC_OFF_OAH  = 8'hC6;
	localparam logic [7:0] TWC_OFF_FLG  = 8'hC7;
	localparam logic [7:0] TWC_OFF_BINT = 8'hD7;
	localparam logic [7:0] TWC_OFF_BCR1 = 8'hD9;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int TWC_B_STROBE = 7;
	localparam int TWC_B_ROLE   = 6;
	localparam int TWC_B_SPEED  = 5;
	localparam int TWC_B_STOP   = 4;
	localparam int TWC_B_SRST   = 5;
	localparam int TWC_B_EN     = 0;
	localparam int TWC_B_SEL    = 1;
	localparam logic [7:0] TWC_RST_CR1  = 8'h00;
	localparam logic [7:0] TWC_RST_CR2  = 8'h20;
	localparam logic [7:0] TWC_RST_BCR1 = 8'h09;

	// ****************************************************************
	// Bus constants
	// ****************************************************************
	localparam logic [4:0] TWC_TEN_PREFIX = 5'h1E;
	localparam logic [3:0] TWC_ACK_SLOT   = 4'h8;
	localparam logic [3:0] TWC_ACK_CLK    = 4'h9;
	localparam logic [3:0] TWC_ACK_DONE   = 4'hA;
	localparam int         TWC_FIFO_W     = 8;
	localparam int         TWC_FIFO_D     = 32;
	localparam logic [7:0] TWC_DIV_FAST [0:7] = '{8'h0A, 8'h0F, 8'h14, 8'h19,
		8'h1E, 8'h28, 8'h32, 8'h3C};
	localparam logic [7:0] TWC_DIV_STD  [0:7] = '{8'h28, 8'h3C, 8'h50, 8'h64,
		8'h78, 8'hA0, 8'hC8, 8'hF0};

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [3:0] {
		TWC_IDLE, TWC_M_START, TWC_M_BIT, TWC_M_STOP, TWC_M_HOLD,
		TWC_S_RX, TWC_S_TX, TWC_S_WAIT, TWC_S_IGN
	} twc_state_e;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} twc_sfr_req_s;

	typedef struct packed {
		logic scl_out;
		logic scl_oe_n;
		logic sda_out;
		logic sda_oe_n;
	} twc_pad_s;

endpackage : twc_pkg

// *** verif/twc_ctrl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker
// ****************************************************************
module twc_ctrl_assertions
	import twc_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire twc_sfr_req_s sfr_req,
	input  wire logic   [7:0] sfr_rdata,
	input  wire logic         scl_in,
	input  wire logic         sda_in,
	input  wire twc_pad_s     pad
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// Open-drain pads never drive high
	pad_low_a: assert property (pad.scl_out == 1'b0 && pad.sda_out == 1'b0)
		else $error("pad output level not zero");
	read_hold_a: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	unmapped_read_a: assert property (sfr_req.rd && sfr_req.addr == 8'h00 |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	bcr1_low_a: assert property (sfr_req.rd && sfr_req.addr == TWC_OFF_BCR1 |=> sfr_rdata[3:0] == 4'h9)
		else $error("second port status low bits wrong");
	cr2_reserved_a: assert property (sfr_req.rd && sfr_req.addr == TWC_OFF_CR2 |=> !sfr_rdata[6])
		else $error("reserved control bit read high");
	oah_reserved_a: assert property (sfr_req.rd && sfr_req.addr == TWC_OFF_OAH |=> sfr_rdata[7:2] == 6'h00)
		else $error("own address high reserved bits set");
	srst_release_a: assert property (sfr_req.wr && sfr_req.addr == TWC_OFF_CR2 && !sfr_req.wdata[TWC_B_SRST]
		|-> ##[1:3] (pad.scl_oe_n && pad.sda_oe_n))
		else $error("soft reset left a pad driven");
	tsa_clear_a: assert property (sfr_req.wr && sfr_req.addr == TWC_OFF_TSA
		##[1:2] sfr_req.rd && sfr_req.addr == TWC_OFF_CR1 |=> !sfr_rdata[3])
		else $error("address sent flag not cleared");
	dbuf_clear_a: assert property (sfr_req.wr && sfr_req.addr == TWC_OFF_DBUF
		##[1:2] sfr_req.rd && sfr_req.addr == TWC_OFF_CR1 |=> !sfr_rdata[0])
		else $error("transmit empty flag not cleared");
	flag_clear_a: assert property (sfr_req.wr && sfr_req.addr == TWC_OFF_FLG && sfr_req.wdata[1:0] == 2'h0
		##[1:2] sfr_req.rd && sfr_req.addr == TWC_OFF_FLG |=> sfr_rdata[1:0] == 2'h0)
		else $error("status flags not cleared by write");
endmodule : twc_ctrl_assertions

bind twc_ctrl twc_ctrl_assertions i_twc_ctrl_assertions (.mclk(mclk), .rst_n(rst_n),
	.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .scl_in(scl_in), .sda_in(sda_in), .pad(pad));
`default_nettype wire

// *** verif/twc_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Two-wire receiving peer
// ****************************************************************
module twc_peer (
	input  wire logic       mclk,
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       nack,
	output logic            sda_oe_n,
	output logic      [7:0] last_byte,
	output int              period
);
	logic [3:0] cnt = 4'h0;
	logic [7:0] sh = 8'h00;
	int         ticks = 0;
	initial sda_oe_n = 1'b1;
	// Start or stop restarts the bit count
	always @(sda) if (scl === 1'b1) cnt = 4'h0;
	// Shift in on SCL rise and log the SCL period
	always @(posedge scl) begin
		if (cnt < 4'h8) sh = {sh[6:0], sda};
		cnt = cnt + 4'h1;
		period = ticks;
		ticks = 0;
	end
	// Answer only in the ack slot, released otherwise
	always @(negedge scl) begin
		sda_oe_n = (cnt == 4'h8) ? nack : 1'b1;
		if (cnt == 4'h8) last_byte = sh;
		if (cnt == 4'h9) cnt = 4'h0;
	end
	// Free cycle count for period checks
	always @(posedge mclk) ticks = ticks + 1;
endmodule : twc_peer
`default_nettype wire

// *** verif/two_wire_master_slave_controller_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Controller testbench
// ****************************************************************
module two_wire_master_slave_controller_bench import twc_pkg::*;;
	logic         mclk = 1'b0;
	logic         rst_n = 1'b0;
	twc_sfr_req_s req = '0;
	logic   [7:0] rdata;
	twc_pad_s     pad;
	logic         peer_oe_n;
	logic         nack = 1'b0;
	logic   [7:0] peer_byte;
	int           period;
	int           err_count = 0;
	int           tests_run = 0;
	int           cycles = 0;
	logic         m_scl = 1'b1;
	logic         m_sda = 1'b1;
	wire logic    scl_w = pad.scl_oe_n & m_scl;
	wire logic    sda_w = pad.sda_oe_n & peer_oe_n & m_sda;

	twc_ctrl i_twc_ctrl (.mclk(mclk), .rst_n(rst_n), .sfr_req(req), .sfr_rdata(rdata),
		.scl_in(scl_w), .sda_in(sda_w), .pad(pad));
	twc_peer i_twc_peer (.mclk(mclk), .scl(scl_w), .sda(sda_w), .nack(nack),
		.sda_oe_n(peer_oe_n), .last_byte(peer_byte), .period(period));

	// Clock and hang guard
	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			report_and_stop();
		end
	end

	// Register access, started and ended at a falling edge
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		@(negedge mclk);
		req.wr = 1'b0;
		@(negedge mclk);
	endtask : sfr_wr
	task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
		req.rd = 1'b1;
		req.addr = a;
		@(negedge mclk);
		req.rd = 1'b0;
		@(negedge mclk);
		d = rdata;
	endtask : sfr_rd
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		logic [7:0] d;
		sfr_rd(a, d);
		cmp(d & m, exp);
	endtask : chk
	// Poll status until the masked bits drop
	task automatic wait_clr(input logic [7:0] m);
		logic [7:0] d;
		d = m;
		for (int i = 0; i < 400 && (d & m) != 8'h00; i++) sfr_rd(TWC_OFF_CR1, d);
		cmp(d & m, 8'h00);
	endtask : wait_clr

	// Reset values, unmapped and read-only places
	task automatic t_regs;
		logic [7:0] ad [10] = '{8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hD7, 8'hD9, 8'h00};
		logic [7:0] ex [10] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h09, 8'h00};
		for (int i = 0; i < 10; i++) chk(ad[i], 8'hFF, ex[i]);
		sfr_wr(8'h00, 8'hFF);
		chk(8'h00, 8'hFF, 8'h00);
		sfr_wr(TWC_OFF_CR1, 8'h0F);
		chk(TWC_OFF_CR1, 8'hFF, 8'h00);
		sfr_wr(TWC_OFF_OAL, 8'h3C);
		sfr_wr(TWC_OFF_OAH, 8'hFF);
		chk(TWC_OFF_OAL, 8'hFF, 8'h3C);
		chk(TWC_OFF_OAH, 8'hFF, 8'h03);
	endtask : t_regs

	// Address then data byte with STOP, fast then standard rate
	task automatic t_master_write;
		sfr_wr(TWC_OFF_CR2, 8'h21);
		sfr_wr(TWC_OFF_CR1, 8'h60);
		sfr_wr(TWC_OFF_TSA, 8'hA4);
		sfr_wr(TWC_OFF_CR1, 8'hE0);
		wait_clr(8'h80);
		cmp(peer_byte, 8'hA4);
		cmp(period[7:0], 8'h0A);
		chk(TWC_OFF_CR1, 8'h8C, 8'h0C);
		chk(TWC_OFF_FLG, 8'h01, 8'h01);
		chk(TWC_OFF_CR2, 8'h10, 8'h10);
		sfr_wr(TWC_OFF_DBUF, 8'h5A);
		chk(TWC_OFF_CR1, 8'h01, 8'h00);
		sfr_wr(TWC_OFF_CR2, 8'h23);
		sfr_wr(TWC_OFF_CR1, 8'hD0);
		wait_clr(8'h90);
		cmp(peer_byte, 8'h5A);
		cmp(period[7:0], 8'h3C);
		chk(TWC_OFF_CR1, 8'h01, 8'h01);
		chk(TWC_OFF_FLG, 8'h04, 8'h04);
		chk(TWC_OFF_CR2, 8'h10, 8'h00);
		sfr_wr(TWC_OFF_FLG, 8'h00);
		chk(TWC_OFF_FLG, 8'h03, 8'h00);
	endtask : t_master_write

	// Refused address, then soft reset frees the held clock
	task automatic t_nack_reset;
		nack = 1'b1;
		sfr_wr(TWC_OFF_CR2, 8'h21);
		sfr_wr(TWC_OFF_CR1, 8'h60);
		sfr_wr(TWC_OFF_TSA, 8'hA4);
		chk(TWC_OFF_CR1, 8'h08, 8'h00);
		sfr_wr(TWC_OFF_CR1, 8'hE0);
		wait_clr(8'h80);
		chk(TWC_OFF_CR1, 8'h0C, 8'h08);
		cmp({7'h00, pad.scl_oe_n}, 8'h00);
		nack = 1'b0;
		sfr_wr(TWC_OFF_CR2, 8'h01);
		repeat (3) @(negedge mclk);
		cmp({6'h00, pad.scl_oe_n, pad.sda_oe_n}, 8'h03);
	endtask : t_nack_reset

	// Far master: one bit cell, waits while the slave stretches SCL
	task automatic bm_bit(input logic b, output logic s);
		m_sda = b;
		repeat (4) @(negedge mclk);
		m_scl = 1'b1;
		while (scl_w !== 1'b1) @(negedge mclk);
		repeat (4) @(negedge mclk);
		s = sda_w;
		m_scl = 1'b0;
		repeat (4) @(negedge mclk);
	endtask : bm_bit
	task automatic bm_byte(input logic [7:0] d, output logic a);
		logic s;
		for (int i = 7; i >= 0; i--) bm_bit(d[i], s);
		bm_bit(1'b1, a);
	endtask : bm_byte

	// Slave: matched address acked and held, data refused under STOP request
	task automatic t_slave;
		logic a;
		nack = 1'b1;
		sfr_wr(TWC_OFF_CR2, 8'h21);
		sfr_wr(TWC_OFF_CR1, 8'h00);
		sfr_wr(TWC_OFF_OAL, 8'h3C);
		m_sda = 1'b0;
		repeat (4) @(negedge mclk);
		m_scl = 1'b0;
		repeat (4) @(negedge mclk);
		bm_byte(8'h78, a);
		cmp({7'h00, a}, 8'h00);
		chk(TWC_OFF_CR1, 8'h86, 8'h86);
		cmp({7'h00, pad.scl_oe_n}, 8'h00);
		chk(TWC_OFF_CR2, 8'h90, 8'h90);
		chk(TWC_OFF_FLG, 8'h06, 8'h02);
		chk(TWC_OFF_DBUF, 8'hFF, 8'h78);
		chk(TWC_OFF_CR1, 8'h02, 8'h00);
		sfr_wr(TWC_OFF_CR1, 8'h10);
		cmp({7'h00, pad.scl_oe_n}, 8'h01);
		bm_byte(8'h5A, a);
		cmp({7'h00, a}, 8'h01);
		chk(TWC_OFF_CR1, 8'h86, 8'h00);
		m_sda = 1'b0;
		repeat (4) @(negedge mclk);
		m_scl = 1'b1;
		repeat (4) @(negedge mclk);
		m_sda = 1'b1;
		repeat (4) @(negedge mclk);
		chk(TWC_OFF_FLG, 8'h04, 8'h04);
		chk(TWC_OFF_CR2, 8'h90, 8'h00);
	endtask : t_slave

	// Verdict and end of run
	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	// Main sequence
	initial begin
		repeat (3) @(negedge mclk);
		rst_n = 1'b1;
		t_regs();
		t_master_write();
		t_nack_reset();
		t_slave();
		report_and_stop();
	end
endmodule : two_wire_master_slave_controller_bench
`default_nettype wire
